// ### src/cap_scan_pkg.sv
package cap_scan_pkg;
	// Special-function register byte addresses on the local register port
	localparam logic [7:0] CHAN_SELECT_ADDR = 8'h9c;
	localparam logic [7:0] CONFIG_ADDR      = 8'ha0;
	localparam logic [7:0] SCAN_START_ADDR  = 8'ha1;
	localparam logic [7:0] SCAN_END_ADDR    = 8'ha2;
	localparam logic [7:0] CONTROL_ADDR     = 8'ha3;

	// Field positions
	localparam int SOC_LSB   = 4;
	localparam int ACC_LSB   = 0;
	localparam int BUSY_BIT  = 0;
	localparam int DISC_BIT  = 7;
	localparam int CHAN_W    = 6;

	localparam logic [2:0] SOC_AUTO_SCAN = 3'h7;
	localparam logic [7:0] CHAN_SELECT_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET      = 8'h00;
	localparam logic [5:0] CHAN_RESET        = 6'h00;
	localparam int         PIN_COUNT         = 64;

	// Register read and write strobes with address and data
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Handshake toward the analog measurement engine
	typedef struct packed {
		logic       start;
		logic [5:0] chan;
	} conv_cmd_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONVERT,
		ST_WAIT
	} scan_state_t;
endpackage

// ### src/cap_sense_auto_scan.sv
// Behaviour
// - Auto-scan is enabled only when the conversion-start field equals 111b.
// - With auto-scan on, a start-channel write also loads the channel select, unless a channel step lands in the same cycle.
// - With auto-scan on, writing one to the busy flag starts the scan.
// - After the accumulated conversions, step to the next channel and convert at once.
// - Keep stepping until the channel select equals the end channel.
// - After the end channel's conversion, reload the start channel.
// - Other analog sense pins with latch zero are grounded during conversion.
// - Every selected channel gets its accumulated conversions, analog-configured or not.
// - A debug halt lets the current rotation finish before stopping.
// - Scanning stays enabled and converting throughout suspend.
// - A greater-than event on a scanned input during suspend wakes the device.
`timescale 1ns/1ps
module cap_sense_auto_scan (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire cap_scan_pkg::reg_req_t reg_req,
	output logic [7:0]                 reg_rdata,
	output cap_scan_pkg::conv_cmd_t    conv_cmd,
	input  wire logic                  conv_done,
	input  wire logic                  conv_greater,
	input  wire logic                  debug_halt,
	input  wire logic                  suspend,
	input  wire logic [63:0]           pin_analog,
	input  wire logic [63:0]           pin_latch,
	output logic [63:0]                pin_ground,
	output logic                       sense_pin_disconnect,
	output logic                       scan_busy,
	output logic                       wake_request
);
	logic [7:0]                chan_select_reg;
	logic [7:0]                config_reg;
	logic [5:0]                scan_start_reg;
	logic [5:0]                scan_end_reg;
	logic                      busy_reg;
	logic [7:0]                acc_count_reg; // Wide enough for 128 accumulations
	logic                      halt_stop_reg;
	cap_scan_pkg::scan_state_t state_reg;
	cap_scan_pkg::conv_cmd_t   conv_cmd_reg;
	logic [63:0]               pin_ground_reg;
	logic                      wake_reg;
	logic [7:0]                rdata_reg;

	logic       auto_scan_on;
	logic       wr_start;
	logic       wr_busy_one;
	logic       chan_done;
	logic       at_end;
	logic [5:0] chan;
	logic [5:0] chan_next;
	logic       wr_config;
	logic       wr_end;
	logic       wr_chan_sel;

	// Overall flow of one scan
	// Software arms auto-scan through the start field of the config byte
	// Start and end channels are written next, the start write also
	// Lands in the channel select so the first conversion is on it
	// A one written to the busy bit leaves idle for the convert state
	// Convert issues a single start pulse to the measurement engine
	// Wait counts done pulses until the accumulation total is reached
	// Then the channel select steps, or wraps at the end channel
	// And the next start pulse follows two cycles after the done
	// Only a debug halt or clearing the start field ends the run
	// Suspend is not an input to the sequencer on purpose
	// Hazards worth knowing
	// End below start makes the increment wrap through code 63
	// A done pulse outside the wait state is ignored by the sequencer, though it still feeds wake
	// The engine must keep one conversion outstanding at most
	// Channel select writes during a scan redirect it, unless a step lands in the same cycle and wins
	// Limitations
	// No check that a selected channel is bonded out on this package
	// The disconnect bit is passed on, not acted on here
	// Trade-off
	// Registered outputs cost one cycle of latency on every status

	// Number of accumulated conversions per channel, field code n means 2^n
	// Code 7 asks for 128 conversions, hence the eight-bit counter
	// Shift kept inside a function since both the end test
	// And any future status readback would need the same decode
	function automatic logic [7:0] acc_total(input logic [2:0] code);
		acc_total = 8'h01 << code;
	endfunction

	function automatic logic is_write(input cap_scan_pkg::reg_req_t req, input logic [7:0] a);
		is_write = req.wr && (req.addr == a);
	endfunction

	// Decodes shared by the register and sequencer processes
	// Write decodes are address compares with the strobe, the busy write also tests its data bit
	// Reads have no side effects, so only writes are decoded here
	// Auto-scan on follows the stored field, not the write in flight
	// So a busy write in the same cycle as arming is refused
	assign auto_scan_on = config_reg[cap_scan_pkg::SOC_LSB +: 3] == cap_scan_pkg::SOC_AUTO_SCAN;
	assign wr_config    = is_write(reg_req, cap_scan_pkg::CONFIG_ADDR);
	assign wr_end       = is_write(reg_req, cap_scan_pkg::SCAN_END_ADDR);
	assign wr_chan_sel  = is_write(reg_req, cap_scan_pkg::CHAN_SELECT_ADDR);
	assign wr_start     = is_write(reg_req, cap_scan_pkg::SCAN_START_ADDR);
	assign wr_busy_one  = is_write(reg_req, cap_scan_pkg::CONTROL_ADDR) && reg_req.wdata[cap_scan_pkg::BUSY_BIT];
	assign chan         = chan_select_reg[cap_scan_pkg::CHAN_W-1:0];
	assign at_end       = chan == scan_end_reg;
	assign chan_done    = (state_reg == cap_scan_pkg::ST_WAIT) && conv_done
		&& (acc_count_reg + 8'h01 >= acc_total(config_reg[cap_scan_pkg::ACC_LSB +: 3]));
	// Ascending code order, so advancing is a plain increment
	assign chan_next    = at_end ? scan_start_reg : chan + 6'h01;

	// Sense configuration: start field and accumulator code
	// Rewritten whole on every write, no partial field update
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			config_reg <= cap_scan_pkg::CONFIG_RESET;
		end else if (wr_config) begin
			config_reg <= reg_req.wdata;
		end
	end

	// Scan start channel, six code bits kept
	// Upper bits of the written byte dropped, they read back as zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_start_reg <= cap_scan_pkg::CHAN_RESET;
		end else if (wr_start) begin
			scan_start_reg <= reg_req.wdata[5:0];
		end
	end

	// Scan end channel, six code bits kept
	// Below the start, the increment wraps through code 63 to zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_end_reg <= cap_scan_pkg::CHAN_RESET;
		end else if (wr_end) begin
			scan_end_reg <= reg_req.wdata[5:0];
		end
	end

	// Channel select; sequencer advance outranks a coincident software write
	// Bit 7 is the disconnect control, bit 6 always stored as zero
	// Stepping and start-channel loads leave the top two bits alone
	// A losing software write is simply dropped, no retry
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_select_reg <= cap_scan_pkg::CHAN_SELECT_RESET;
		end else if (auto_scan_on && busy_reg && chan_done) begin
			chan_select_reg <= {chan_select_reg[7:6], chan_next};
		end else if (auto_scan_on && wr_start) begin
			chan_select_reg <= {chan_select_reg[7:6], reg_req.wdata[5:0]};
		end else if (wr_chan_sel) begin
			chan_select_reg <= {reg_req.wdata[7], 1'b0, reg_req.wdata[5:0]};
		end
	end

	// Debug halt is remembered so the rotation ends at the wrap, not mid-way
	// A short halt pulse early in a rotation still stops it at the end
	// Cleared once idle so a later scan starts without a stale stop
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			halt_stop_reg <= 1'b0;
		end else if (!busy_reg) begin
			halt_stop_reg <= 1'b0;
		end else if (debug_halt) begin
			halt_stop_reg <= 1'b1;
		end
	end

	// Sequencer: busy runs on through suspend, only halt or disable ends it
	// Idle waits for an armed busy write
	// Convert issues exactly one start pulse, then waits
	// Wait counts done pulses against the accumulation total
	// Leaving the start field ends the run at the next wait cycle
	// Start pulse cleared by default so it never stands two cycles
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg     <= cap_scan_pkg::ST_IDLE;
			busy_reg      <= 1'b0;
			acc_count_reg <= 8'h00;
			conv_cmd_reg  <= '0;
		end else begin
			conv_cmd_reg.start <= 1'b0;
			unique case (state_reg)
				cap_scan_pkg::ST_IDLE: begin
					if (auto_scan_on && wr_busy_one) begin
						// Armed state is read from the stored config only
						busy_reg      <= 1'b1;
						acc_count_reg <= 8'h00;
						state_reg     <= cap_scan_pkg::ST_CONVERT;
					end
				end
				cap_scan_pkg::ST_CONVERT: begin
					// No analog-input check: every selected channel is tried
					conv_cmd_reg.start <= 1'b1;
					conv_cmd_reg.chan  <= chan;
					state_reg          <= cap_scan_pkg::ST_WAIT;
				end
				cap_scan_pkg::ST_WAIT: begin
					if (!auto_scan_on) begin
						busy_reg  <= 1'b0;
						state_reg <= cap_scan_pkg::ST_IDLE;
					end else if (conv_done && !chan_done) begin
						// More accumulations due on the same channel
						acc_count_reg <= acc_count_reg + 8'h01;
						state_reg     <= cap_scan_pkg::ST_CONVERT;
					end else if (chan_done) begin
						// Channel finished; select steps in the same edge
						acc_count_reg <= 8'h00;
						if (at_end && (halt_stop_reg || debug_halt)) begin
							busy_reg  <= 1'b0;
							state_reg <= cap_scan_pkg::ST_IDLE;
						end else begin
							state_reg <= cap_scan_pkg::ST_CONVERT;
						end
					end
				end
			endcase
		end
	end

	// Grounding of idle analog pins while a conversion is in flight
	// Follows the live channel, so it settles with the start pulse
	// Pins driven high by the port latch are left alone
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_ground_reg <= '0;
		end else begin
			for (int i = 0; i < cap_scan_pkg::PIN_COUNT; i++) begin
				pin_ground_reg[i] <= (state_reg != cap_scan_pkg::ST_IDLE) && pin_analog[i]
					&& !pin_latch[i] && (i != int'(chan));
			end
		end
	end

	// Wake: greater-than result while suspended and scanning
	// The result is only trusted in the cycle of the done pulse
	// One pulse per qualifying conversion, the system keeps it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_reg <= 1'b0;
		end else begin
			wake_reg <= suspend && busy_reg && conv_done && conv_greater;
		end
	end

	// Read data, registered; unmapped addresses read zero
	// Holds until the next read so software may sample late
	// Busy reads the internal flag, one cycle ahead of the status pin
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
		end else if (reg_req.rd) begin
			unique case (reg_req.addr)
				cap_scan_pkg::CHAN_SELECT_ADDR: rdata_reg <= chan_select_reg;
				cap_scan_pkg::CONFIG_ADDR:      rdata_reg <= config_reg;
				cap_scan_pkg::SCAN_START_ADDR:  rdata_reg <= {2'b00, scan_start_reg};
				cap_scan_pkg::SCAN_END_ADDR:    rdata_reg <= {2'b00, scan_end_reg};
				cap_scan_pkg::CONTROL_ADDR:     rdata_reg <= {7'h00, busy_reg};
				default:                        rdata_reg <= 8'h00;
			endcase
		end
	end

	// Disconnect control copied from the channel select byte
	// Registered again so the pin never glitches on a write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sense_pin_disconnect <= 1'b0;
		end else begin
			sense_pin_disconnect <= chan_select_reg[cap_scan_pkg::DISC_BIT];
		end
	end

	// Busy status pin, one cycle behind the internal flag
	// Trade-off: a clean flop output for one cycle of lag
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_busy <= 1'b0;
		end else begin
			scan_busy <= busy_reg;
		end
	end

	// Remaining outputs are plain wires from their flip-flops

	assign reg_rdata    = rdata_reg;
	assign conv_cmd     = conv_cmd_reg;
	assign pin_ground   = pin_ground_reg;
	assign wake_request = wake_reg;
endmodule

// ### testbench/cap_sense_auto_scan_assertions.sv
`timescale 1ns/1ps
module cap_scan_checker (
	input wire logic                    ref_clk,
	input wire logic                    rst_n,
	input wire cap_scan_pkg::reg_req_t  reg_req,
	input wire cap_scan_pkg::conv_cmd_t conv_cmd,
	input wire logic                    conv_done,
	input wire logic                    conv_greater,
	input wire logic                    debug_halt,
	input wire logic                    suspend,
	input wire logic [63:0]             pin_analog,
	input wire logic [63:0]             pin_latch,
	input wire logic [63:0]             pin_ground,
	input wire logic                    scan_busy,
	input wire logic                    wake_request
);
	logic [5:0] start_q, end_q, last_q;
	logic [2:0] acc_q;
	logic [7:0] n_q;
	logic       auto_q, valid_q;
	wire        step = n_q == (8'h1 << acc_q);
	wire        wr_cfg = reg_req.wr && reg_req.addr == cap_scan_pkg::CONFIG_ADDR;
	wire        stop = debug_halt && last_q == end_q && step;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Shadow of setup; valid_q drops once busy falls so a new scan starts clean
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{start_q, end_q, last_q, acc_q, n_q, auto_q, valid_q} <= '0;
		end else begin
			if (reg_req.wr && reg_req.addr == cap_scan_pkg::SCAN_START_ADDR) start_q <= reg_req.wdata[5:0];
			if (reg_req.wr && reg_req.addr == cap_scan_pkg::SCAN_END_ADDR) end_q <= reg_req.wdata[5:0];
			if (wr_cfg) auto_q <= reg_req.wdata[6:4] == cap_scan_pkg::SOC_AUTO_SCAN;
			if (wr_cfg) acc_q <= reg_req.wdata[2:0];
			if (conv_cmd.start) last_q <= conv_cmd.chan;
			if (conv_cmd.start) n_q <= (!valid_q || step) ? 8'h1 : n_q + 8'h1;
			valid_q <= (valid_q && scan_busy) || conv_cmd.start;
		end
	end
	a_no_auto_start: assert property (!auto_q |-> !conv_cmd.start) else $error("start without auto-scan");
	a_first_chan: assert property (conv_cmd.start && !valid_q |-> conv_cmd.chan == start_q)
		else $error("first channel not the start channel");
	a_next_chan: assert property (conv_cmd.start && valid_q |-> conv_cmd.chan ==
		(!step ? last_q : (last_q == end_q ? start_q : last_q + 6'h1))) else $error("wrong next channel");
	a_start_pulse: assert property (conv_cmd.start |=> !conv_cmd.start) else $error("start held too long");
	a_done_restart: assert property (conv_done && !stop |-> ##2 conv_cmd.start)
		else $error("no start after done");
	a_halt_stop: assert property (conv_done && stop |=> !conv_cmd.start [*4]) else $error("scan ran on");
	a_ground_pins: assert property (conv_cmd.start |->
		pin_ground == (pin_analog & ~pin_latch & ~(64'h1 << conv_cmd.chan))) else $error("grounding wrong");
	a_wake_cause: assert property (wake_request == $past(suspend && scan_busy && conv_done && conv_greater))
		else $error("wake mismatch");
endmodule
bind cap_sense_auto_scan cap_scan_checker u_chk (.ref_clk, .rst_n, .reg_req, .conv_cmd, .conv_done, .conv_greater,
	.debug_halt, .suspend, .pin_analog, .pin_latch, .pin_ground, .scan_busy, .wake_request);

// ### testbench/conv_engine_model.sv
`timescale 1ns/1ps
module conv_engine_model (
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire cap_scan_pkg::conv_cmd_t conv_cmd,
	input  wire logic                    slow,
	input  wire logic                    greater_en,
	output logic                         conv_done,
	output logic                         conv_greater
);
	int wait_q;
	// One conversion in flight; the flag toggles outside done so it is never trusted
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= 0;
			conv_done <= 1'b0;
			conv_greater <= 1'b0;
		end else begin
			conv_done <= wait_q == 1;
			conv_greater <= (wait_q == 1) ? greater_en : ~conv_greater;
			if (conv_cmd.start) wait_q <= slow ? 12 : 2;
			else if (wait_q != 0) wait_q <= wait_q - 1;
		end
	end
endmodule

// ### testbench/cap_sense_auto_scan_bench.sv
`timescale 1ns/1ps
module cap_sense_auto_scan_bench;
	logic                    ref_clk, rst_n, conv_done, conv_greater, debug_halt, suspend, slow, greater_en;
	logic                    sense_pin_disconnect, scan_busy, wake_request;
	logic [7:0]              reg_rdata;
	logic [63:0]             pin_analog, pin_latch, pin_ground;
	logic [5:0]              ch;
	cap_scan_pkg::reg_req_t  reg_req;
	cap_scan_pkg::conv_cmd_t conv_cmd;
	int                      err_total, checks, seed, cycles, start_cnt, wake_cnt, want, wake_want, s, e, rot;
	cap_sense_auto_scan u_dut (.ref_clk, .rst_n, .reg_req, .reg_rdata, .conv_cmd, .conv_done, .conv_greater, .debug_halt,
		.suspend, .pin_analog, .pin_latch, .pin_ground, .sense_pin_disconnect, .scan_busy, .wake_request);
	conv_engine_model u_eng (.ref_clk, .rst_n, .conv_cmd, .slow, .greater_en, .conv_done, .conv_greater);
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Strobe lowered a full edge before the next request may raise it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		reg_req <= '0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		reg_req <= '0;
		repeat (2) @(posedge ref_clk);
		chk(reg_rdata, exp, "read data");
	endtask
	task automatic wait_start;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (conv_cmd.start !== 1'b1 && n < 60);
		ch = conv_cmd.chan;
	endtask
	function automatic logic [5:0] exp_chan(input int s, input int e, input int acc, input int i);
		return 6'(s + (i >> acc) % (e - s + 1));
	endfunction
	// Tallies and the hang guard
	always @(posedge ref_clk) begin
		cycles++;
		start_cnt += int'(conv_cmd.start === 1'b1);
		wake_cnt += int'(wake_request === 1'b1);
		if (cycles == 6000) begin
			err_total++;
			report_and_stop;
		end
	end
	initial begin
		seed = 32'h1ddea7b1;
		{rst_n, debug_halt, suspend, slow, greater_en} = '0;
		{reg_req, pin_analog, pin_latch} = '0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(cap_scan_pkg::CHAN_SELECT_ADDR, cap_scan_pkg::CHAN_SELECT_RESET);
		rd(8'h55, 8'h00);
		// Start field short of all ones: a busy write must not scan
		wr(cap_scan_pkg::CONFIG_ADDR, 8'h30);
		wr(cap_scan_pkg::CONTROL_ADDR, 8'h01);
		repeat (20) @(posedge ref_clk);
		chk(start_cnt, 0, "starts");
		$display("test auto-off done");
		// Second reset clears any busy left by the refused start
		rst_n <= 1'b0;
		@(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		// Bit 6 stores as zero, bit 7 reaches the disconnect pin
		wr(cap_scan_pkg::CHAN_SELECT_ADDR, 8'hc5);
		rd(cap_scan_pkg::CHAN_SELECT_ADDR, 8'h85);
		chk(sense_pin_disconnect, 1'b1, "disconnect");
		wr(cap_scan_pkg::CHAN_SELECT_ADDR, 8'h00);
		rd(cap_scan_pkg::CHAN_SELECT_ADDR, 8'h00);
		chk(sense_pin_disconnect, 1'b0, "disconnect");
		$display("test channel select done");
		for (int k = 0; k < 4; k++) begin
			s = $random(seed) & 63;
			if (s > 60) s = 60;
			e = s + (k == 0 ? 0 : $random(seed) & 3);
			rot = (e - s + 1) << k;
			want = start_cnt + 2 * rot;
			wake_want += (k == 2) ? 2 * rot : 0;
			suspend <= k == 2;
			greater_en <= k >= 2;
			slow <= 1'($random(seed));
			pin_analog <= {$random(seed), $random(seed)};
			pin_latch <= {$random(seed), $random(seed)};
			wr(cap_scan_pkg::CONFIG_ADDR, {1'b0, cap_scan_pkg::SOC_AUTO_SCAN, 4'(k)});
			wr(cap_scan_pkg::SCAN_START_ADDR, 8'(s));
			rd(cap_scan_pkg::CHAN_SELECT_ADDR, 8'(s));
			wr(cap_scan_pkg::SCAN_END_ADDR, 8'(e));
			wr(cap_scan_pkg::CONTROL_ADDR, 8'h01);
			// Halt lands early in the second rotation, which must still complete
			for (int i = 0; i < 2 * rot; i++) begin
				wait_start;
				chk(ch, exp_chan(s, e, k, i), "channel");
				if (i == rot) debug_halt <= 1'b1;
			end
			repeat (30) @(posedge ref_clk);
			chk(scan_busy, 1'b0, "busy after halt");
			chk(start_cnt, want, "starts");
			chk(wake_cnt, wake_want, "wakes");
			debug_halt <= 1'b0;
			$display("test scan %0d done", k);
		end
		report_and_stop;
	end
endmodule
